/* File: pkg/i2cm_pkg.sv */
// constants, types and register map of the two-wire master sequencer
`default_nettype none
package i2cm_pkg;
   localparam logic [7:0] ADDR_BUF = 8'h00;
   localparam logic [7:0] ADDR_DIV = 8'h04;
   localparam logic [7:0] ADDR_CTL = 8'h08;
   localparam logic [7:0] ADDR_STS = 8'h0C;
   localparam int CTL_START = 0;
   localparam int CTL_RESTART = 1;
   localparam int CTL_STOP = 2;
   localparam int CTL_W = 5;
   localparam int STS_BF = 0;
   localparam int STS_WRITE_COLLISION_FLAG = 1;
   localparam int STS_ACK = 2;
   localparam int STS_IRQ = 3;
   localparam int STS_BCL = 4;
   localparam int STS_SDET = 5;
   localparam int STS_PDET = 6;
   localparam logic [7:0] DIV_RST = 8'h04;
   localparam logic [7:0] BUF_RST = 8'h00;
   localparam logic [3:0] BIT_LAST_DATA = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   typedef struct packed {
      logic scl;
      logic sda;
   } i2cm_line_s;
   localparam i2cm_line_s LINE_RST = '{scl: 1'b1, sda: 1'b1};
   typedef enum logic [15:0] {
      S_IDLE = 16'h0001,
      S_ST_W = 16'h0002,
      S_ST_H = 16'h0004,
      S_RS_A = 16'h0008,
      S_RS_B = 16'h0010,
      S_RS_C = 16'h0020,
      S_RS_D = 16'h0040,
      S_RS_E = 16'h0080,
      S_TX_L = 16'h0100,
      S_TX_R = 16'h0200,
      S_TX_H = 16'h0400,
      S_SP_A = 16'h0800,
      S_SP_B = 16'h1000,
      S_SP_C = 16'h2000,
      S_SP_D = 16'h4000,
      S_SP_E = 16'h8000
   } i2cm_state_e;
endpackage : i2cm_pkg
`default_nettype wire

/* File: logic/i2cm_seq.sv */
// two-wire master sequencer: start, restart, stop, byte transmit, ahb-lite registers
//
// Contract
// - released scl pauses baud counter until high
// - scl sampled high reloads counter from divisor
// - buffer write while busy discarded, collision flag
// - control low bits ignored during start
// - start: lines high, count, then sda low
// - second start period, clear request, hold sda
// - start collision when lines low, abort
// - restart accepted only while sequencer idle
// - restart: scl low, release sda, release scl
// - restart: both high period, sda low period
// - restart end clears request, keeps sda low
// - restart irq only after counter timeout
// - restart collision on sda low or scl fall
// - idle buffer write sets full, starts transmit
// - bit after scl fall, low then high period
// - eight bits sent msb first from buffer
// - eighth fall clears full, releases sda
// - ack captured on ninth clock rising edge
// - ack status zero on ack, one on nack
// - after ninth clock irq, halt, scl low
// - stop or restart irq when fully generated
// - request bit self-clears with completion irq
//
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`default_nettype none
module i2cm_seq
   import i2cm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe
);
   i2cm_state_e state;
   i2cm_line_s s1, s2, s3, lf, lp;
   logic [7:0] cnt, divisor, tbuf, shreg;
   logic [3:0] bitn;
   logic [CTL_W-1:0] ctl;
   logic scl_low, sda_low, bf, ack, write_collision_flag, irq, bcl, sdet, pdet;
   logic dp_wr;
   logic [7:0] dp_addr;
   logic tmo, counting, idle_q, ev_bcl, ev_irq;
   logic buf_wr, ctl_wr, sts_wr, div_wr;
   logic [31:0] next_rdata;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = scl_low;
   assign sda_oe = sda_low;

   // bus address phase captured for the following data phase
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         dp_wr <= 1'b0;
         dp_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
      end
      else if (hready)
      begin
         dp_wr <= hsel && htrans[1] && hwrite;
         dp_addr <= haddr[7:0];
         hrdata <= (hsel && htrans[1] && !hwrite) ? next_rdata : 32'h0000_0000;
      end
   end

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      unique case (haddr[7:0])
         ADDR_BUF: next_rdata[7:0] = tbuf;
         ADDR_DIV: next_rdata[7:0] = divisor;
         ADDR_CTL: next_rdata[CTL_W-1:0] = ctl;
         ADDR_STS:
         begin
            next_rdata[STS_BF] = bf;
            next_rdata[STS_WRITE_COLLISION_FLAG] = write_collision_flag;
            next_rdata[STS_ACK] = ack;
            next_rdata[STS_IRQ] = irq;
            next_rdata[STS_BCL] = bcl;
            next_rdata[STS_SDET] = sdet;
            next_rdata[STS_PDET] = pdet;
         end
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   assign buf_wr = dp_wr && (dp_addr == ADDR_BUF);
   assign div_wr = dp_wr && (dp_addr == ADDR_DIV);
   assign ctl_wr = dp_wr && (dp_addr == ADDR_CTL);
   assign sts_wr = dp_wr && (dp_addr == ADDR_STS);

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         divisor <= DIV_RST;
      else if (div_wr)
         divisor <= hwdata[7:0];
   end

   // pin synchronisers; a level counts once stages two and three agree
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s1 <= LINE_RST;
         s2 <= LINE_RST;
         s3 <= LINE_RST;
         lf <= LINE_RST;
         lp <= LINE_RST;
      end
      else
      begin
         s1 <= '{scl: scl_in, sda: sda_in};
         s2 <= s1;
         s3 <= s2;
         if (s2.scl == s3.scl)
            lf.scl <= s3.scl;
         if (s2.sda == s3.sda)
            lf.sda <= s3.sda;
         lp <= lf;
      end
   end

   // period ends when the countdown reaches zero
   assign tmo = (cnt == 8'h00);
   assign counting = (state == S_ST_W) || (state == S_ST_H) || (state == S_RS_B)
      || (state == S_RS_D) || (state == S_RS_E) || (state == S_TX_L)
      || (state == S_TX_H) || (state == S_SP_B) || (state == S_SP_D)
      || (state == S_SP_E);
   assign idle_q = (state == S_IDLE) && (ctl == '0);

   // collision and completion events
   always_comb
   begin
      ev_bcl = 1'b0;
      ev_irq = 1'b0;
      if ((state == S_IDLE) && ctl[CTL_START] && !lf.scl && !lf.sda)
         ev_bcl = 1'b1;
      if ((state == S_ST_W) && (!lf.scl || (tmo && !lf.sda)))
         ev_bcl = 1'b1;
      if ((state == S_RS_B) && tmo && !lf.sda)
         ev_bcl = 1'b1;
      if ((state == S_RS_C) && lf.scl && !lf.sda)
         ev_bcl = 1'b1;
      if ((state == S_RS_D) && (!lf.scl || !lf.sda))
         ev_bcl = 1'b1;
      // released data bit read low while clock high
      if ((state == S_TX_H) && !sda_low && (bitn != BIT_ACK) && !lf.sda)
         ev_bcl = 1'b1;
      if (tmo && ((state == S_ST_H) || (state == S_RS_E) || (state == S_SP_E)))
         ev_irq = 1'b1;
      if ((state == S_TX_H) && tmo && (bitn == BIT_ACK))
         ev_irq = 1'b1;
   end

   // sticky flags; a set in the clearing cycle wins
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         write_collision_flag <= 1'b0;
         irq <= 1'b0;
         bcl <= 1'b0;
         sdet <= 1'b0;
         pdet <= 1'b0;
      end
      else
      begin
         write_collision_flag <= (buf_wr && !idle_q) || (write_collision_flag && !(sts_wr && hwdata[STS_WRITE_COLLISION_FLAG]));
         irq <= ev_irq || (irq && !(sts_wr && hwdata[STS_IRQ]));
         bcl <= ev_bcl || (bcl && !(sts_wr && hwdata[STS_BCL]));
         sdet <= (lp.sda && !lf.sda && lf.scl && lp.scl)
            || (sdet && !(sts_wr && hwdata[STS_SDET]));
         pdet <= (!lp.sda && lf.sda && lf.scl && lp.scl)
            || (pdet && !(sts_wr && hwdata[STS_PDET]));
      end
   end

   // sequencer, baud counter and line drive
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state <= S_IDLE;
         cnt <= 8'h00;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
         ctl <= '0;
         bf <= 1'b0;
         ack <= 1'b0;
         tbuf <= BUF_RST;
         shreg <= BUF_RST;
         bitn <= 4'h0;
      end
      else if (ev_bcl)
      begin
         // abort: release both lines, drop requests
         state <= S_IDLE;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
         ctl <= '0;
         bf <= 1'b0;
      end
      else
      begin
         if (counting && !tmo)
            cnt <= cnt - 8'h01;
         unique case (state)
            S_IDLE:
            begin
               if (ctl_wr && idle_q)
                  ctl <= hwdata[CTL_W-1:0];
               // idle buffer write launches the byte
               if (buf_wr && idle_q)
               begin
                  tbuf <= hwdata[7:0];
                  shreg <= hwdata[7:0];
                  bf <= 1'b1;
                  scl_low <= 1'b1;
                  cnt <= divisor;
                  bitn <= 4'h0;
                  state <= S_TX_L;
               end
               else if (ctl[CTL_START])
               begin
                  // both lines high: load and count
                  if (lf.scl && lf.sda)
                  begin
                     cnt <= divisor;
                     state <= S_ST_W;
                  end
               end
               else if (ctl[CTL_RESTART])
               begin
                  scl_low <= 1'b1;
                  state <= S_RS_A;
               end
               else if (ctl[CTL_STOP])
               begin
                  scl_low <= 1'b1;
                  sda_low <= 1'b1;
                  state <= S_SP_A;
               end
            end
            S_ST_W:
               if (tmo)
               begin
                  sda_low <= 1'b1;
                  cnt <= divisor;
                  state <= S_ST_H;
               end
            S_ST_H:
               if (tmo)
               begin
                  ctl[CTL_START] <= 1'b0;
                  state <= S_IDLE;
               end
            S_RS_A:
               // clock seen low: release data and count
               if (!lf.scl)
               begin
                  sda_low <= 1'b0;
                  cnt <= divisor;
                  state <= S_RS_B;
               end
            S_RS_B:
               if (tmo)
               begin
                  scl_low <= 1'b0;
                  state <= S_RS_C;
               end
            S_RS_C:
               if (lf.scl)
               begin
                  cnt <= divisor;
                  state <= S_RS_D;
               end
            S_RS_D:
               if (tmo)
               begin
                  sda_low <= 1'b1;
                  cnt <= divisor;
                  state <= S_RS_E;
               end
            S_RS_E:
               // end without reload, data held low
               if (tmo)
               begin
                  scl_low <= 1'b1;
                  ctl[CTL_RESTART] <= 1'b0;
                  state <= S_IDLE;
               end
            S_TX_L:
            begin
               // bit or release one cycle after the fall
               sda_low <= (bitn != BIT_ACK) && !shreg[7];
               if (tmo)
               begin
                  scl_low <= 1'b0;
                  state <= S_TX_R;
               end
            end
            S_TX_R:
               // wait for stretched clock, then reload
               if (lf.scl)
               begin
                  cnt <= divisor;
                  state <= S_TX_H;
                  if (bitn == BIT_ACK)
                     ack <= lf.sda;
               end
            S_TX_H:
               if (tmo)
               begin
                  scl_low <= 1'b1;
                  if (bitn == BIT_ACK)
                     // halt with clock low, data released
                     state <= S_IDLE;
                  else
                  begin
                     bitn <= bitn + 4'h1;
                     cnt <= divisor;
                     shreg <= {shreg[6:0], 1'b0};
                     state <= S_TX_L;
                     // eighth fall clears full; data released in the low phase
                     if (bitn == BIT_LAST_DATA)
                        bf <= 1'b0;
                  end
               end
            S_SP_A:
               if (!lf.sda)
               begin
                  cnt <= divisor;
                  state <= S_SP_B;
               end
            S_SP_B:
               if (tmo)
               begin
                  scl_low <= 1'b0;
                  state <= S_SP_C;
               end
            S_SP_C:
               if (lf.scl)
               begin
                  cnt <= divisor;
                  state <= S_SP_D;
               end
            S_SP_D:
               if (tmo)
               begin
                  sda_low <= 1'b0;
                  cnt <= divisor;
                  state <= S_SP_E;
               end
            S_SP_E:
               if (tmo)
               begin
                  ctl[CTL_STOP] <= 1'b0;
                  state <= S_IDLE;
               end
            default:
               state <= S_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   property p_pause;
      (state == S_TX_R) && !lf.scl |=> $stable(cnt);
   endproperty
   a_pause: assert property (p_pause) else $error("counter moved while clock held");

   property p_reload;
      (state == S_TX_R) && lf.scl && !ev_bcl |=> (cnt == divisor) && (state == S_TX_H);
   endproperty
   a_reload: assert property (p_reload) else $error("no reload on clock high");

   property p_write_collision_flag;
      buf_wr && !idle_q |=> write_collision_flag && $stable(tbuf);
   endproperty
   a_write_collision_flag: assert property (p_write_collision_flag) else $error("busy buffer write not refused");

   property p_start_low;
      (state == S_ST_W) && tmo && !ev_bcl |=> sda_low && scl_oe == 1'b0;
   endproperty
   a_start_low: assert property (p_start_low) else $error("start did not pull data");

   property p_start_bcl;
      (state == S_ST_W) && !lf.scl |=> bcl && (state == S_IDLE) && !ctl[CTL_START];
   endproperty
   a_start_bcl: assert property (p_start_bcl) else $error("start collision missed");

   property p_restart_busy;
      ctl_wr && !idle_q && !ctl[CTL_RESTART] |=> !ctl[CTL_RESTART];
   endproperty
   a_restart_busy: assert property (p_restart_busy) else $error("restart taken while busy");

   property p_launch;
      buf_wr && idle_q |=> bf && scl_low && (state == S_TX_L) ##1 (cnt == $past(divisor) - 8'h01);
   endproperty
   a_launch: assert property (p_launch) else $error("idle write did not launch");

   property p_ack;
      (state == S_TX_R) && lf.scl && (bitn == BIT_ACK) |=> ack == $past(lf.sda);
   endproperty
   a_ack: assert property (p_ack) else $error("ack status wrong");

   property p_ninth;
      (state == S_TX_H) && tmo && (bitn == BIT_ACK) && !ev_bcl
         |=> irq && scl_low && !sda_low && !bf && (state == S_IDLE);
   endproperty
   a_ninth: assert property (p_ninth) else $error("ninth clock end wrong");

   property p_eighth;
      (state == S_TX_H) && tmo && (bitn == BIT_LAST_DATA) && !ev_bcl |=> !bf ##1 !sda_low;
   endproperty
   a_eighth: assert property (p_eighth) else $error("eighth fall did not release");
endmodule : i2cm_seq
`default_nettype wire

/* File: testbench/i2cm_slave_model.sv */
// behavioural slave on the two-wire bus: captures bytes, acknowledges, stretches, forces lines
`default_nettype none
module i2cm_slave_model
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda,
   input wire logic ack_en,
   input wire logic stretch_en,
   input wire logic hold_scl,
   input wire logic hold_sda,
   output logic scl_pull,
   output logic sda_pull,
   output logic [7:0] rx_byte,
   output logic [3:0] start_count
);
   logic scl_q;
   logic sda_q;
   logic ack_drv;
   logic [3:0] rise_n;
   logic [4:0] stretch_cnt;
   // released lines fall back to the pull-up level
   assign scl_pull = hold_scl | (stretch_cnt != 5'h00);
   assign sda_pull = hold_sda | ack_drv;
   always_ff @(posedge clk_sys)
   begin
      scl_q <= scl;
      sda_q <= sda;
      if (rst)
      begin
         rise_n <= 4'h0;
         ack_drv <= 1'h0;
         stretch_cnt <= 5'h00;
         rx_byte <= 8'h00;
         start_count <= 4'h0;
      end
      else if (scl && sda_q && !sda)
      begin
         rise_n <= 4'h0;
         start_count <= start_count + 4'h1;
      end
      else if (scl && !scl_q)
      begin
         if (rise_n < 4'h8)
            rx_byte <= {rx_byte[6:0], sda};
         rise_n <= rise_n + 4'h1;
      end
      else if (!scl && scl_q)
      begin
         // ack driven from the eighth fall to the ninth fall
         ack_drv <= ack_en && (rise_n == 4'h8);
         if (rise_n == 4'h9)
            rise_n <= 4'h0;
         stretch_cnt <= stretch_en ? 5'h10 : 5'h00;
      end
      else if (stretch_cnt != 5'h00)
         stretch_cnt <= stretch_cnt - 5'h01;
   end
endmodule : i2cm_slave_model
`default_nettype wire

/* File: testbench/i2cm_seq_tb.sv */
// self-checking bench of the two-wire master sequencer
`default_nettype none
module i2cm_seq_tb
   import i2cm_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'h0;
   logic rst = 1'h1;
   logic hsel = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic scl_out;
   logic scl_oe;
   logic sda_out;
   logic sda_oe;
   logic ack_en = 1'h0;
   logic stretch_en = 1'h0;
   logic hold_scl = 1'h0;
   logic hold_sda = 1'h0;
   logic slv_scl;
   logic slv_sda;
   logic [7:0] rx_byte;
   logic [3:0] start_count;
   logic [3:0] starts;
   wire logic hready;
   wire logic scl_w;
   wire logic sda_w;
   int err_count = 0;
   int check_count = 0;
   int cycles = 0;
   assign hready = hreadyout;
   // open-drain lines with pull-ups
   assign scl_w = ~(scl_oe | slv_scl);
   assign sda_w = ~(sda_oe | slv_sda);
   i2cm_seq i2cm_seq_inst (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_in(scl_w),
      .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
   i2cm_slave_model i2cm_slave_model_inst (.clk_sys(clk_sys), .rst(rst), .scl(scl_w),
      .sda(sda_w), .ack_en(ack_en), .stretch_en(stretch_en), .hold_scl(hold_scl),
      .hold_sda(hold_sda), .scl_pull(slv_scl), .sda_pull(slv_sda), .rx_byte(rx_byte),
      .start_count(start_count));
   always #2.5 clk_sys = ~clk_sys;
   task automatic give_verdict();
      if (err_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge clk_sys); while (hready !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hready !== 1'h1);
      r = hrdata;
      if (w)
         @(posedge clk_sys);
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(a, 1'h1, d, r);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      xfer(a, 1'h0, 32'h0, r);
      check(r & m, e);
   endtask : rd_chk
   task automatic wait_bit(input int idx);
      logic [31:0] r;
      // polls until the flag shows; only the bench timeout ends a hang
      do
         xfer(ADDR_STS, 1'h0, 32'h0, r);
      while (r[idx] !== 1'h1);
   endtask : wait_bit
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         err_count++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'h0;
      @(posedge clk_sys);
      check({30'h0, scl_oe, sda_oe}, 32'h0);
      check({28'h0, hreadyout, hresp, scl_out, sda_out}, 32'h8);
      rd_chk(ADDR_DIV, 32'hFF, {24'h0, DIV_RST});
      rd_chk(ADDR_STS, 32'h7F, 32'h0);
      rd_chk(8'h10, 32'hFFFFFFFF, 32'h0);
      wr(ADDR_DIV, 32'h3);
      rd_chk(ADDR_DIV, 32'hFF, 32'h3);
      wr(ADDR_CTL, 32'h1);
      wr(ADDR_BUF, 32'h55);
      wr(ADDR_CTL, 32'h2);
      wait_bit(STS_IRQ);
      rd_chk(ADDR_CTL, 32'h1F, 32'h0);
      rd_chk(ADDR_BUF, 32'hFF, {24'h0, BUF_RST});
      rd_chk(ADDR_STS, 32'h2A, 32'h2A);
      check({30'h0, scl_oe, sda_oe}, 32'h1);
      wr(ADDR_STS, 32'h2A);
      ack_en <= 1'h1;
      wr(ADDR_BUF, 32'hA5);
      rd_chk(ADDR_STS, 32'h1, 32'h1);
      wr(ADDR_CTL, 32'h2);
      wait_bit(STS_IRQ);
      check({24'h0, rx_byte}, 32'hA5);
      rd_chk(ADDR_STS, 32'hD, 32'h8);
      rd_chk(ADDR_CTL, 32'h1F, 32'h0);
      check({30'h0, scl_oe, sda_oe}, 32'h2);
      wr(ADDR_STS, 32'h8);
      ack_en <= 1'h0;
      stretch_en <= 1'h1;
      wr(ADDR_BUF, 32'h3C);
      wait_bit(STS_IRQ);
      check({24'h0, rx_byte}, 32'h3C);
      rd_chk(ADDR_STS, 32'h5, 32'h4);
      stretch_en <= 1'h0;
      wr(ADDR_STS, 32'h8);
      starts = start_count;
      wr(ADDR_CTL, 32'h2);
      wait_bit(STS_IRQ);
      rd_chk(ADDR_CTL, 32'h1F, 32'h0);
      check({28'h0, start_count}, {28'h0, starts + 4'h1});
      check({30'h0, scl_oe, sda_oe}, 32'h3);
      rd_chk(ADDR_STS, 32'h30, 32'h20);
      wr(ADDR_STS, 32'h28);
      wr(ADDR_CTL, 32'h4);
      wait_bit(STS_IRQ);
      rd_chk(ADDR_STS, 32'h48, 32'h48);
      check({30'h0, scl_oe, sda_oe}, 32'h0);
      wr(ADDR_STS, 32'h48);
      hold_scl <= 1'h1;
      hold_sda <= 1'h1;
      repeat (5) @(posedge clk_sys);
      wr(ADDR_CTL, 32'h1);
      wait_bit(STS_BCL);
      rd_chk(ADDR_CTL, 32'h1F, 32'h0);
      check({30'h0, scl_oe, sda_oe}, 32'h0);
      rd_chk(ADDR_STS, 32'h18, 32'h10);
      hold_scl <= 1'h0;
      hold_sda <= 1'h0;
      // clock pulled low by another device during the start wait
      wr(ADDR_STS, 32'h10);
      wr(ADDR_DIV, 32'h40);
      wr(ADDR_CTL, 32'h1);
      hold_scl <= 1'h1;
      wait_bit(STS_BCL);
      rd_chk(ADDR_CTL, 32'h1F, 32'h0);
      check({30'h0, scl_oe, sda_oe}, 32'h0);
      hold_scl <= 1'h0;
      give_verdict();
   end
endmodule : i2cm_seq_tb
`default_nettype wire
